//--- design/fws_bus_cycle.sv
`timescale 1ns/10ps
`default_nettype none
// executes one read or write cycle on the flash pins
module fws_bus_cycle
  import fws_pkg::*;
#(
  parameter int AW = 22
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // request side
  fws_bus_if.slave bus,
  // flash pins
  output logic [AW-1:0] fl_addr,
  output logic fl_ce_n,
  output logic fl_oe_n,
  output logic fl_we_n,
  input wire logic [7:0] data_lines_in,
  output logic [7:0] data_lines_out,
  output logic data_lines_oe
);
  import fws_pkg::*;

  // the address must fit the pins and the strobe counts the 4-bit counter
  if (AW < 1 || AW > 32 || FWS_READ_CYC > 15 || FWS_WRITE_CYC > 15) begin : g_param_check
    $error("bus cycle parameters out of range");
  end

  typedef struct packed {
    logic busy;
    logic wr;
    logic [3:0] cnt;
    logic done;
    logic [7:0] rdata;
    logic [AW-1:0] addr;
    logic [7:0] wdata;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic drv;
  } fws_cyc_type;

  fws_cyc_type s_q, s_d;

  // hold strobes for a fixed number of cycles, then sample and release
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (!s_q.busy) begin
      if (bus.req) begin
        s_d.busy = 1'b1;
        s_d.wr = bus.wr;
        s_d.addr = bus.addr;
        s_d.wdata = bus.wdata;
        s_d.cnt = bus.wr ? 4'(FWS_WRITE_CYC) : 4'(FWS_READ_CYC);
        s_d.ce_n = 1'b0;
        s_d.oe_n = bus.wr;
        s_d.we_n = ~bus.wr;
        s_d.drv = bus.wr;
      end
    end else if (s_q.cnt != 4'h0) begin
      s_d.cnt = s_q.cnt - 4'h1;
    end else begin
      // the byte is taken while oe_n is still low, then all strobes rise together
      s_d.busy = 1'b0;
      s_d.done = 1'b1;
      s_d.rdata = data_lines_in;
      s_d.ce_n = 1'b1;
      s_d.oe_n = 1'b1;
      s_d.we_n = 1'b1;
      s_d.drv = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.done = s_q.done;
  assign bus.rdata = s_q.rdata;
  assign fl_addr = s_q.addr;
  // pins come straight from flops so no decode glitch reaches the flash strobes
  assign fl_ce_n = s_q.ce_n;
  assign fl_oe_n = s_q.oe_n;
  assign fl_we_n = s_q.we_n;
  assign data_lines_out = s_q.wdata;
  assign data_lines_oe = s_q.drv;

  // every request is answered within 8 cycles of being accepted
  AST_CYCLE_ENDS: assert property (@(posedge ref_clk) disable iff (!resetn)
    bus.req && !s_q.busy |-> ##[1:8] s_q.done) else $error("bus cycle never ended");
endmodule : fws_bus_cycle
`default_nettype wire

//--- design/fws_bus_if.sv
`timescale 1ns/10ps
`default_nettype none
// one flash bus cycle between poller and bus engine
interface fws_bus_if #(parameter int AW = 22);
  logic req;
  logic wr;
  logic [AW-1:0] addr;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;
  modport master (output req, output wr, output addr, output wdata, input done, input rdata);
  modport slave (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface : fws_bus_if
`default_nettype wire

//--- design/fws_pkg.sv
package fws_pkg;
  // data line bit positions
  localparam int FWS_BIT_POLL = 7;
  localparam int FWS_BIT_TOG1 = 6;
  localparam int FWS_BIT_FAIL = 5;
  localparam int FWS_BIT_WIN = 3;
  localparam int FWS_BIT_TOG2 = 2;
  // bus timing in clock cycles (50 ns each)
  localparam int FWS_READ_CYC = 2;
  localparam int FWS_WRITE_CYC = 2;
  // flash reset command (single bus write of F0)
  localparam logic [7:0] FWS_RESET_CMD = 8'hF0;
  // outcome codes
  localparam logic [1:0] FWS_RES_NONE = 2'h0;
  localparam logic [1:0] FWS_RES_DONE = 2'h1;
  localparam logic [1:0] FWS_RES_FAIL = 2'h2;
  localparam logic [1:0] FWS_RES_WIN_LATE = 2'h3;
endpackage : fws_pkg

//--- design/fws_status_poller.sv
`timescale 1ns/10ps
`default_nettype none
// How it works
// - start polling with two back-to-back full reads
// - toggling with fail flag: recheck, then reset
// - resumed polling restarts from first double read
// - after any fail, write reset command
// - fast sector commands need no window check
// - check window flag before and after commands
// - poll at program address or erasing sector
module fws_status_poller
  import fws_pkg::*;
#(
  parameter int AW = 22
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // user orders
  input wire logic start,
  input wire logic abandon,
  input wire logic win_check,
  input wire logic [AW-1:0] poll_addr,
  // user answers
  output logic busy,
  output logic result_valid,
  output logic [1:0] result_code,
  output logic win_flag,
  output logic [7:0] last_data,
  output logic ready_seen,
  // flash pins
  output logic [AW-1:0] fl_addr,
  output logic fl_ce_n,
  output logic fl_oe_n,
  output logic fl_we_n,
  input wire logic [7:0] data_lines_in,
  output logic [7:0] data_lines_out,
  output logic data_lines_oe,
  input wire logic ready_busy_n
);
  import fws_pkg::*;

  // the address must fit the pins
  if (AW < 1 || AW > 32) begin : g_aw_check
    $error("AW out of range");
  end

  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_RD1 = 7'b0000010,
    ST_RD2 = 7'b0000100,
    ST_RD3 = 7'b0001000,
    ST_RD4 = 7'b0010000,
    ST_RST = 7'b0100000,
    ST_WIN = 7'b1000000
  } fws_state_type;

  typedef struct packed {
    fws_state_type st;
    logic req;
    logic wr;
    logic fail_seen;
    logic [7:0] first;
    logic quit;
    logic busy;
    logic rv;
    logic [1:0] code;
    logic win;
    logic [7:0] last;
    logic rdy;
  } fws_poll_type;

  fws_poll_type s_q, s_d;
  fws_bus_if #(.AW(AW)) bus ();
  logic tog;

  fws_bus_cycle #(.AW(AW)) u_cyc (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .bus(bus.slave),
    .fl_addr(fl_addr),
    .fl_ce_n(fl_ce_n),
    .fl_oe_n(fl_oe_n),
    .fl_we_n(fl_we_n),
    .data_lines_in(data_lines_in),
    .data_lines_out(data_lines_out),
    .data_lines_oe(data_lines_oe)
  );

  // reads go to the user address, valid for program or erase sector
  assign bus.req = s_q.req;
  assign bus.wr = s_q.wr;
  assign bus.addr = poll_addr;
  assign bus.wdata = FWS_RESET_CMD;
  // toggle one differs between the two reads
  assign tog = s_q.first[FWS_BIT_TOG1] ^ bus.rdata[FWS_BIT_TOG1];

  // polling sequencer
  always_comb begin
    s_d = s_q;
    s_d.req = 1'b0;
    s_d.rv = 1'b0;
    s_d.rdy = ready_busy_n; // device releases high when idle or suspended
    if ((abandon || s_q.quit) && s_q.st != ST_IDLE && s_q.st != ST_RST) begin
      // the read on the pins is let finish so the engine is free for the next start;
      // history is dropped and the next start redoes the double read
      s_d.quit = 1'b1;
      if (bus.done) begin
        s_d.st = ST_IDLE;
        s_d.busy = 1'b0;
        s_d.quit = 1'b0;
      end
    end else begin
      case (s_q.st)
        ST_IDLE: begin
          if (start) begin
            s_d.st = ST_RD1; // always begin at first read
            s_d.req = 1'b1;
            s_d.wr = 1'b0;
            s_d.busy = 1'b1;
            s_d.fail_seen = 1'b0;
          end else if (win_check) begin
            // optional window read; fast sector commands skip it
            s_d.st = ST_WIN;
            s_d.req = 1'b1;
            s_d.wr = 1'b0;
            s_d.busy = 1'b1;
          end
        end
        ST_RD1: begin
          if (bus.done) begin
            s_d.first = bus.rdata;
            s_d.st = ST_RD2;
            s_d.req = 1'b1; // second read straight after
          end
        end
        ST_RD3: begin
          if (bus.done) begin
            // first read of a fresh pair; a lone re-read could compare status with array
            s_d.first = bus.rdata;
            s_d.st = ST_RD4;
            s_d.req = 1'b1;
          end
        end
        ST_RD2, ST_RD4: begin
          if (bus.done) begin
            s_d.last = bus.rdata;
            if (!tog) begin
              // stopped toggling: finished, following reads are array
              s_d.st = ST_IDLE;
              s_d.busy = 1'b0;
              s_d.rv = 1'b1;
              s_d.code = FWS_RES_DONE;
            end else if (s_q.st == ST_RD4 && s_q.fail_seen) begin
              // still toggling after fail flag: write reset
              s_d.st = ST_RST;
              s_d.req = 1'b1;
              s_d.wr = 1'b1;
            end else begin
              s_d.fail_seen = bus.rdata[FWS_BIT_FAIL];
              s_d.st = ST_RD3; // still toggling: judge again from a new pair
              s_d.req = 1'b1;
            end
          end
        end
        ST_RST: begin
          if (bus.done) begin
            s_d.st = ST_IDLE;
            s_d.busy = 1'b0;
            s_d.rv = 1'b1;
            s_d.code = FWS_RES_FAIL;
            s_d.wr = 1'b0;
          end
        end
        ST_WIN: begin
          if (bus.done) begin
            // high means erase began and new sectors are refused
            s_d.win = bus.rdata[FWS_BIT_WIN];
            s_d.last = bus.rdata;
            s_d.st = ST_IDLE;
            s_d.busy = 1'b0;
            s_d.rv = 1'b1;
            s_d.code = bus.rdata[FWS_BIT_WIN] ? FWS_RES_WIN_LATE : FWS_RES_NONE;
          end
        end
        default: begin
          s_d.st = ST_IDLE;
          s_d.busy = 1'b0;
        end
      endcase
    end
  end

  // state register; reset leaves no result and the pins idle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '{st: ST_IDLE, code: FWS_RES_NONE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign busy = s_q.busy;
  assign result_valid = s_q.rv;
  assign result_code = s_q.code;
  assign win_flag = s_q.win;
  assign last_data = s_q.last;
  assign ready_seen = s_q.rdy;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_DOUBLE_READ: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_q.st == ST_IDLE && start && !abandon |=> s_q.st == ST_RD1 && s_q.req)
    else $error("polling did not begin with a read");
  AST_DONE_ON_STILL: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_q.st == ST_RD2 && bus.done && !tog && !abandon && !s_q.quit
      |=> result_valid && result_code == FWS_RES_DONE)
    else $error("steady toggle not reported done");
  AST_FAIL_RESET: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_q.st == ST_RD4 && s_q.fail_seen && bus.done && tog && !abandon && !s_q.quit
      |=> s_q.st == ST_RST && s_q.wr)
    else $error("failure did not issue reset");
  AST_RESET_WRITE: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_q.st == ST_RST && bus.done |=> result_code == FWS_RES_FAIL)
    else $error("reset write not reported as fail");
  AST_ABANDON: assert property (@(posedge ref_clk) disable iff (!resetn)
    abandon && s_q.st inside {ST_RD1, ST_RD2, ST_RD3, ST_RD4}
      |-> ##[1:6] s_q.st == ST_IDLE)
    else $error("abandon did not restart");
  AST_WIN_FLAG: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_q.st == ST_WIN && bus.done |=> win_flag == $past(bus.rdata[FWS_BIT_WIN]))
    else $error("window flag not captured");
  AST_RDY_FOLLOW: assert property (@(posedge ref_clk) disable iff (!resetn)
    1'b1 |=> ready_seen == $past(ready_busy_n))
    else $error("ready/busy not followed");
  AST_NO_WRITE_POLL: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_q.st inside {ST_RD1, ST_RD2, ST_RD3, ST_RD4} |-> fl_we_n && !data_lines_oe)
    else $error("write during poll");
  COV_DONE: cover property (@(posedge ref_clk) result_valid && result_code == FWS_RES_DONE);
  COV_FAIL: cover property (@(posedge ref_clk) result_valid && result_code == FWS_RES_FAIL);
  COV_WIN: cover property (@(posedge ref_clk) result_valid && result_code == FWS_RES_WIN_LATE);
  COV_ABANDON: cover property (@(posedge ref_clk) s_q.quit && bus.done);
endmodule : fws_status_poller
`default_nettype wire

//--- verification/fws_flash_model.sv
`timescale 1ns/10ps
`default_nettype none
// behavioural flash device answering status reads
module fws_flash_model
  import fws_pkg::*;
#(
  parameter int AW = 22
) (
  // flash pins
  input wire logic [AW-1:0] fl_addr,
  input wire logic fl_ce_n,
  input wire logic fl_oe_n,
  input wire logic fl_we_n,
  input wire logic [7:0] data_lines_out,
  input wire logic data_lines_oe,
  // device outputs
  output logic [7:0] data_lines_in,
  output logic ready_busy_n
);
  int busy_reads = 0;
  bit fail_on = 0;
  bit fail_late = 0;
  bit erase = 0;
  bit win = 0;
  bit chip = 0;
  bit suspend = 0;
  bit other = 0;
  logic [AW-1:0] rd_addr = '0;
  logic [7:0] wr_byte = 8'h00;
  logic rd_sel, wr_sel;
  int n_reads = 0;
  int n_resets = 0;
  logic [7:0] arr = 8'hA5;
  logic [7:0] last = 8'h00;
  logic tog1 = 1'b0;
  logic tog2 = 1'b0;
  logic active;
  logic [7:0] stat;
  // a failed operation stays busy until the reset command
  assign active = (busy_reads > 0) || fail_on;
  assign ready_busy_n = !active;
  // status while busy, array data once finished
  always_comb begin
    stat = arr;
    if (suspend && !other) begin
      stat[7] = 1'b1;
      stat[6] = tog1;
      stat[5] = 1'b0;
      stat[2] = tog2;
    end else if (active) begin
      stat[7] = erase ? 1'b0 : ~arr[7];
      stat[6] = tog1;
      stat[5] = fail_on || (fail_late && busy_reads == 1);
      stat[3] = chip ? arr[3] : win;
      stat[2] = erase ? tog2 : arr[2];
    end
  end
  // strobe pairs judged as one, so chip enable rising with a strobe is no race
  assign rd_sel = !fl_ce_n && !fl_oe_n;
  assign wr_sel = !fl_ce_n && !fl_we_n;
  // released bus shows the inverse of the last byte so stale data never passes
  assign data_lines_in = rd_sel ? stat : ~last;
  // each completed read while busy advances toggle one; toggle two advances on reads during erase or of the suspended sector
  always @(negedge rd_sel) begin
    last = stat;
    rd_addr = fl_addr;
    n_reads++;
    if (active) tog1 = ~tog1;
    if ((active && erase) || (suspend && !other)) tog2 = ~tog2;
    if (busy_reads > 0) busy_reads--;
  end
  // the byte on the lines is kept while the write strobe is low
  always @(wr_sel, data_lines_oe, data_lines_out) begin
    if (wr_sel && data_lines_oe) wr_byte = data_lines_out;
  end
  // reset command returns the device to array reads; a started erase that has not failed ignores it
  always @(negedge wr_sel) begin
    if (wr_byte == FWS_RESET_CMD && !(erase && win && !fail_on && busy_reads > 0)) begin
      fail_on = 0;
      busy_reads = 0;
      n_resets++;
    end
    wr_byte = 8'h00;
  end
endmodule : fws_flash_model
`default_nettype wire

//--- verification/fws_status_poller_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module fws_status_poller_tb_top;
  import fws_pkg::*;
  logic ref_clk = 0, resetn = 0, start = 0, abandon = 0, win_check = 0;
  logic [21:0] poll_addr = 22'h012340;
  logic busy, result_valid, win_flag, ready_seen, fl_ce_n, fl_oe_n, fl_we_n, dl_oe, rb_n;
  logic [1:0] result_code;
  logic [7:0] last_data, dl_in, dl_out;
  logic [21:0] fl_addr;
  logic [15:0] lfsr = 16'h004D;
  int n_fail = 0, num_checks = 0, n_rv = 0;
  // ---------------------------------------------
  // clock, design and device
  // ---------------------------------------------
  always #25 ref_clk = ~ref_clk;
  // result pulses, counted where they have settled
  always @(negedge ref_clk) if (result_valid === 1'b1) n_rv++;
  fws_status_poller u_dut (.ref_clk(ref_clk), .resetn(resetn), .start(start),
    .abandon(abandon), .win_check(win_check), .poll_addr(poll_addr), .busy(busy),
    .result_valid(result_valid), .result_code(result_code), .win_flag(win_flag),
    .last_data(last_data), .ready_seen(ready_seen), .fl_addr(fl_addr), .fl_ce_n(fl_ce_n),
    .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .data_lines_in(dl_in), .data_lines_out(dl_out),
    .data_lines_oe(dl_oe), .ready_busy_n(rb_n));
  fws_flash_model u_model (.fl_addr(fl_addr), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
    .fl_we_n(fl_we_n), .data_lines_out(dl_out), .data_lines_oe(dl_oe),
    .data_lines_in(dl_in), .ready_busy_n(rb_n));
  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  // a failing operation must end in the fail code, anything else in done
  function automatic logic [7:0] exp_code(input bit fail);
    return fail ? {6'h00, FWS_RES_FAIL} : {6'h00, FWS_RES_DONE};
  endfunction : exp_code
  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task results;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  // bounded wait for the sequence to finish
  task wait_idle;
    int i;
    i = 0;
    while (busy !== 1'b0 && i < 3000) begin
      @(negedge ref_clk);
      i++;
    end
    if (i >= 3000) begin
      n_fail++;
      $display("BAD wait_idle timed out");
      results();
    end
  endtask : wait_idle
  task automatic pulse(ref logic sig);
    @(negedge ref_clk);
    sig = 1;
    @(negedge ref_clk);
    sig = 0;
  endtask : pulse
  // one polled operation against a device set up to end as asked
  task run(input int reads, input bit fail, input bit late);
    int r0, s0, v0;
    u_model.busy_reads = reads;
    u_model.fail_on = fail;
    u_model.fail_late = late;
    r0 = u_model.n_reads;
    s0 = u_model.n_resets;
    v0 = n_rv;
    pulse(start);
    wait_idle();
    @(negedge ref_clk);
    check("result_code", {6'h00, result_code}, exp_code(fail));
    check("double_read", 8'(u_model.n_reads - r0 >= 2), 8'h01);
    check("reset_cmd", 8'(u_model.n_resets - s0), {7'h00, fail});
    check("ready_seen", {7'h00, ready_seen}, 8'h01);
    check("result_pulse", 8'(n_rv - v0), 8'h01);
    check("poll_addr", 8'(u_model.rd_addr == poll_addr), 8'h01);
    if (!fail) check("last_data", last_data, u_model.arr);
    $display("test op reads %0d fail %0d late %0d finished", reads, fail, late);
  endtask : run
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    repeat (6) @(negedge ref_clk);
    resetn = 1;
    run(0, 0, 0);
    run(0, 1, 0);
    run(2, 0, 1);
    // abandoned polling, then a fresh start
    u_model.busy_reads = 500;
    pulse(start);
    repeat (20) @(negedge ref_clk);
    check("ready_busy", {7'h00, ready_seen}, 8'h00);
    pulse(abandon);
    wait_idle();
    run(3, 0, 0);
    // erase window flag read back both ways
    u_model.erase = 1;
    u_model.busy_reads = 300;
    for (int w = 0; w < 3; w++) begin
      bit e;
      u_model.chip = w[1];
      u_model.win = w[0] | w[1];
      e = w[1] ? u_model.arr[3] : w[0];
      pulse(win_check);
      wait_idle();
      check("win_flag", {7'h00, win_flag}, {7'h00, e});
      check("win_code", 8'(result_code), 8'(e ? FWS_RES_WIN_LATE : FWS_RES_NONE));
    end
    $display("test window finished");
    u_model.erase = 0;
    u_model.chip = 0;
    // erase suspended: the suspended sector, then a sector outside the erase
    u_model.busy_reads = 0;
    u_model.suspend = 1;
    for (int s = 0; s < 2; s++) begin
      logic [7:0] sx;
      u_model.other = s[0];
      sx = s[0] ? {6'h00, u_model.arr[7], u_model.arr[5]} : 8'h02;
      pulse(start);
      wait_idle();
      @(negedge ref_clk);
      check("susp_code", 8'(result_code), 8'(FWS_RES_DONE));
      check("susp_bits", {6'h00, last_data[7], last_data[5]}, sx);
      check("susp_ready", {7'h00, ready_seen}, 8'h01);
    end
    u_model.suspend = 0;
    $display("test suspend finished");
    for (int k = 0; k < 8; k++) begin
      lfsr = lfsr_next(lfsr);
      u_model.arr = lfsr[15:8];
      poll_addr = {6'h00, lfsr};
      run(int'(lfsr[2:0]), lfsr[3], lfsr[4] & ~lfsr[3]);
    end
    results();
  end
endmodule : fws_status_poller_tb_top
`default_nettype wire
